// ===== design/psa_pkg.sv
// shared constants and carrier types of the program-flow and addressing unit
package psa_pkg;
	localparam int          PC_W          = 15;
	localparam int          LATCH_W       = 7;
	localparam int          DEPTH         = 16;
	localparam int          PTR_W         = 5;
	localparam int          CALL_OP_W     = 11;
	localparam int          REL_OP_W      = 9;
	localparam int          SEL_W         = 16;
	localparam int          DM_ADDR_W     = 12;
	localparam int          FLASH_W       = 14;
	localparam logic [14:0] PC_RESET      = 15'h0000;
	localparam logic [6:0]  LATCH_RESET   = 7'h00;
	localparam logic [4:0]  PTR_EMPTY     = 5'h1f;
	localparam logic [4:0]  PTR_TOP       = 5'h0f;
	localparam logic [15:0] SEL_RESET     = 16'h0000;
	localparam logic [15:0] TRAD_LAST     = 16'h0fff;
	localparam logic [15:0] LIN_FIRST     = 16'h2000;
	localparam logic [15:0] LIN_LAST      = 16'h29af;
	localparam int          FLASH_BIT     = 15;
	localparam logic [11:0] RAM_BLOCK     = 12'h050;
	localparam logic [11:0] RAM_BASE      = 12'h020;
	localparam int          BANK_SHIFT    = 7;
	localparam logic [6:0]  WIN0_OFFSET   = 7'h00;
	localparam logic [6:0]  WIN1_OFFSET   = 7'h01;

	typedef enum logic [7:0] {
		OP_ADVANCE    = 8'h01,
		OP_WRITE_LOW  = 8'h02,
		OP_CALL       = 8'h04,
		OP_CALL_W     = 8'h08,
		OP_BRANCH_W   = 8'h10,
		OP_BRANCH_REL = 8'h20,
		OP_RETURN     = 8'h40,
		OP_VECTOR     = 8'h80
	} psa_op_kind_t;

	typedef enum logic [2:0] {
		IND_IDLE  = 3'b001,
		IND_MEM   = 3'b010,
		IND_EXTRA = 3'b100
	} psa_ind_state_t;

	typedef enum logic [3:0] {
		REG_NONE  = 4'b0001,
		REG_DATA  = 4'b0010,
		REG_FLASH = 4'b0100,
		REG_NULL  = 4'b1000
	} psa_region_t;

	typedef struct packed {
		psa_op_kind_t kind;
		logic [10:0]  call_target;
		logic [8:0]   rel_offset;
		logic [7:0]   w_value;
		logic [7:0]   low_data;
		logic [14:0]  vector_addr;
	} psa_op_t;

	typedef struct packed {
		logic       sel;
		logic       write;
		logic [7:0] wdata;
	} psa_ind_req_t;
endpackage

// ===== design/psa_unit.sv
// program counter, return stack and indirect addressing unit
`timescale 1ns/1ps

// Notes on behaviour
// (RULE1) a low-byte write also loads counter bits 14:8 from the high latch
// (RULE2) direct call takes operand bits 10:0 and latch bits 6:3
// (RULE3) computed call takes low byte from w and upper bits from the latch
// (RULE4) branch by w sets counter to counter plus one plus unsigned w
// (RULE5) relative branch sets counter to counter plus one plus signed operand
// (RULE6) sixteen entry return stack of fifteen bits, outside all address spaces
// (RULE7) calls and vectoring push, returns pop; the high latch is untouched
// (RULE8) with fault reset disabled the stack wraps and overwrites oldest entries
// (RULE9) overflow and underflow flags set on every fault in either mode
// (RULE10) five bit pointer; top entry registers follow the selected entry
// (RULE11) push increments pointer then stores; pop restores then decrements
// (RULE12) empty pointer is 0x1f, first push gives 0x00, return gives 0x1f
// (RULE13) with fault reset enabled a fault requests a device reset and sets flag
// (RULE14) window accesses go to the pointer address; self address reads zero
// (RULE15) each pointer is a sixteen bit address from its high and low byte
// (RULE16) pointer addresses 0x000 to 0xfff map to absolute data addresses
// (RULE17) 0x2000 to 0x29af map onto 80 byte blocks; unimplemented reads zero
// (RULE18) top pointer bit selects flash; low eight bits read, writes dropped
// (RULE19) flash reads through the window take one extra cycle
// (RULE20) any reset clears the whole counter
// (RULE21) otherwise the counter advances by one per fetched instruction
module psa_unit (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire logic                 core_reset,
	input  wire logic                 op_valid,
	input  wire psa_pkg::psa_op_t     op,
	input  wire logic                 latch_wr,
	input  wire logic [6:0]           latch_wdata,
	output logic [14:0]               program_counter,
	output logic [6:0]                counter_high_latch,
	input  wire logic                 stack_fault_reset_enable,
	input  wire logic                 ptr_reg_wr,
	input  wire logic [4:0]           ptr_reg_wdata,
	input  wire logic                 top_high_wr,
	input  wire logic                 top_low_wr,
	input  wire logic [7:0]           top_wdata,
	output logic [4:0]                stack_pointer_reg,
	output logic [6:0]                top_entry_high,
	output logic [7:0]                top_entry_low,
	input  wire logic                 overflow_clear,
	input  wire logic                 underflow_clear,
	output logic                      stack_overflow_flag,
	output logic                      stack_underflow_flag,
	output logic                      stack_fault_reset,
	input  wire logic [1:0]           pointer_low_wr,
	input  wire logic [1:0]           pointer_high_wr,
	input  wire logic [7:0]           pointer_wdata,
	output logic [15:0]               file_select_pointer0,
	output logic [15:0]               file_select_pointer1,
	input  wire logic                 ind_valid,
	input  wire psa_pkg::psa_ind_req_t ind_req,
	output logic                      ind_ready,
	output logic                      ind_done,
	output logic [7:0]                ind_rdata,
	output logic [11:0]               dm_addr,
	output logic                      dm_rd,
	output logic                      dm_wr,
	output logic [7:0]                dm_wdata,
	input  wire logic [7:0]           dm_rdata,
	output logic [14:0]               flash_addr,
	output logic                      flash_rd,
	input  wire logic [13:0]          flash_rdata
);
	logic [14:0]             pc_q;
	logic [6:0]              latch_q;
	logic [4:0]              ptr_q;
	logic [14:0]             stack_q [psa_pkg::DEPTH];
	logic                    ovf_q;
	logic                    unf_q;
	logic                    fault_q;
	logic [15:0]             sel_ptr_q [2];
	psa_pkg::psa_ind_state_t ind_state_q;
	psa_pkg::psa_region_t    region_q;
	logic                    wr_q;
	logic [11:0]             dm_addr_q;
	logic [14:0]             flash_addr_q;
	logic [7:0]              wdata_q;
	logic [7:0]              rdata_q;
	logic                    done_q;
	logic                    push;
	logic                    pop;
	logic                    push_ovf;
	logic                    pop_unf;
	logic [3:0]              top_idx;
	logic [14:0]             pc_next_seq;
	psa_pkg::psa_region_t    req_region;
	logic [11:0]             req_dm_addr;
	logic [15:0]             req_addr;

	// linear region offset to absolute data address
	function automatic logic [11:0] linear_to_abs(input logic [15:0] a);
		logic [11:0] n;
		logic [11:0] bank;
		logic [11:0] off;
		n    = 12'(a - psa_pkg::LIN_FIRST);
		bank = n / psa_pkg::RAM_BLOCK;
		off  = n % psa_pkg::RAM_BLOCK;
		return 12'(bank << psa_pkg::BANK_SHIFT) + psa_pkg::RAM_BASE + off;
	endfunction

	// true when an absolute data address is one of the two window registers
	function automatic logic is_window(input logic [11:0] a);
		return (a[6:0] == psa_pkg::WIN0_OFFSET) || (a[6:0] == psa_pkg::WIN1_OFFSET);
	endfunction

	assign push        = op_valid && (op.kind == psa_pkg::OP_CALL || op.kind == psa_pkg::OP_CALL_W
	                     || op.kind == psa_pkg::OP_VECTOR); // see (RULE7)
	assign pop         = op_valid && (op.kind == psa_pkg::OP_RETURN); // see (RULE7)
	assign push_ovf    = push && (ptr_q == psa_pkg::PTR_TOP);
	assign pop_unf     = pop && (ptr_q == psa_pkg::PTR_EMPTY);
	assign top_idx     = ptr_q[3:0];
	assign pc_next_seq = 15'(pc_q + 15'h0001);

	// program counter
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= psa_pkg::PC_RESET; // see (RULE20)
		end else if (core_reset) begin
			pc_q <= psa_pkg::PC_RESET; // see (RULE20)
		end else if (op_valid) begin
			case (op.kind)
				psa_pkg::OP_ADVANCE: begin
					pc_q <= pc_next_seq; // see (RULE21)
				end
				psa_pkg::OP_WRITE_LOW: begin
					pc_q <= {latch_q, op.low_data}; // see (RULE1)
				end
				psa_pkg::OP_CALL: begin
					pc_q <= {latch_q[6:3], op.call_target}; // see (RULE2)
				end
				psa_pkg::OP_CALL_W: begin
					pc_q <= {latch_q, op.w_value}; // see (RULE3)
				end
				psa_pkg::OP_BRANCH_W: begin
					pc_q <= 15'(pc_next_seq + {7'h00, op.w_value}); // see (RULE4)
				end
				psa_pkg::OP_BRANCH_REL: begin
					pc_q <= 15'(pc_next_seq + {{6{op.rel_offset[8]}}, op.rel_offset}); // see (RULE5)
				end
				psa_pkg::OP_RETURN: begin
					pc_q <= stack_q[top_idx]; // see (RULE11)
				end
				psa_pkg::OP_VECTOR: begin
					pc_q <= op.vector_addr;
				end
				default: begin
					pc_q <= pc_q;
				end
			endcase
		end
	end

	// high latch, written only by software
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_q <= psa_pkg::LATCH_RESET;
		end else if (core_reset) begin
			latch_q <= psa_pkg::LATCH_RESET;
		end else if (latch_wr) begin
			latch_q <= latch_wdata; // see (RULE7)
		end
	end

	// stack pointer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= psa_pkg::PTR_EMPTY; // see (RULE12)
		end else if (core_reset) begin
			ptr_q <= psa_pkg::PTR_EMPTY;
		end else if (push) begin
			ptr_q <= push_ovf ? 5'h00 : 5'(ptr_q + 5'h01); // see (RULE8) (RULE11) (RULE12)
		end else if (pop) begin
			ptr_q <= pop_unf ? psa_pkg::PTR_EMPTY : 5'(ptr_q - 5'h01); // see (RULE11) (RULE12)
		end else if (ptr_reg_wr) begin
			ptr_q <= ptr_reg_wdata; // see (RULE10)
		end
	end

	// stack storage: the push writes the slot the incremented pointer selects
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < psa_pkg::DEPTH; i++) begin
				stack_q[i] <= psa_pkg::PC_RESET;
			end
		end else if (push) begin
			stack_q[4'(ptr_q + 5'h01)] <= (op.kind == psa_pkg::OP_VECTOR) ? pc_q
			                              : pc_next_seq; // see (RULE6) (RULE8) (RULE11)
		end else if (!pop && top_high_wr) begin
			stack_q[top_idx][14:8] <= top_wdata[6:0]; // see (RULE10)
		end else if (!pop && top_low_wr) begin
			stack_q[top_idx][7:0] <= top_wdata; // see (RULE10)
		end
	end

	// fault flags survive core reset; a set wins over a clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_q <= 1'b0;
		end else if (push_ovf) begin
			ovf_q <= 1'b1; // see (RULE9) (RULE13)
		end else if (overflow_clear) begin
			ovf_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			unf_q <= 1'b0;
		end else if (pop_unf) begin
			unf_q <= 1'b1; // see (RULE9) (RULE13)
		end else if (underflow_clear) begin
			unf_q <= 1'b0;
		end
	end

	// fault reset request pulse
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= stack_fault_reset_enable && (push_ovf || pop_unf); // see (RULE13)
		end
	end

	// file select pointers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_ptr_q[0] <= psa_pkg::SEL_RESET;
			sel_ptr_q[1] <= psa_pkg::SEL_RESET;
		end else if (core_reset) begin
			sel_ptr_q[0] <= psa_pkg::SEL_RESET;
			sel_ptr_q[1] <= psa_pkg::SEL_RESET;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (pointer_high_wr[i]) begin
					sel_ptr_q[i][15:8] <= pointer_wdata; // see (RULE15)
				end
				if (pointer_low_wr[i]) begin
					sel_ptr_q[i][7:0] <= pointer_wdata; // see (RULE15)
				end
			end
		end
	end

	// decode of the selected pointer
	always_comb begin
		req_addr    = sel_ptr_q[ind_req.sel]; // see (RULE14)
		req_dm_addr = 12'h000;
		req_region  = psa_pkg::REG_NULL;
		if (req_addr[psa_pkg::FLASH_BIT]) begin
			req_region = ind_req.write ? psa_pkg::REG_NULL : psa_pkg::REG_FLASH; // see (RULE18)
		end else if (req_addr <= psa_pkg::TRAD_LAST) begin
			req_dm_addr = req_addr[11:0]; // see (RULE16)
			req_region  = is_window(req_addr[11:0]) ? psa_pkg::REG_NULL
			              : psa_pkg::REG_DATA; // see (RULE14)
		end else if (req_addr >= psa_pkg::LIN_FIRST && req_addr <= psa_pkg::LIN_LAST) begin
			req_dm_addr = linear_to_abs(req_addr); // see (RULE17)
			req_region  = psa_pkg::REG_DATA;
		end
	end

	// indirect access sequencer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ind_state_q  <= psa_pkg::IND_IDLE;
			region_q     <= psa_pkg::REG_NONE;
			wr_q         <= 1'b0;
			dm_addr_q    <= 12'h000;
			flash_addr_q <= 15'h0000;
			wdata_q      <= 8'h00;
			rdata_q      <= 8'h00;
			done_q       <= 1'b0;
		end else if (core_reset) begin
			ind_state_q <= psa_pkg::IND_IDLE;
			region_q    <= psa_pkg::REG_NONE;
			done_q      <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (ind_state_q)
				psa_pkg::IND_IDLE: begin
					if (ind_valid) begin
						ind_state_q  <= psa_pkg::IND_MEM;
						region_q     <= req_region;
						wr_q         <= ind_req.write;
						dm_addr_q    <= req_dm_addr;
						flash_addr_q <= req_addr[14:0]; // see (RULE18)
						wdata_q      <= ind_req.wdata;
					end
				end
				psa_pkg::IND_MEM: begin
					case (region_q)
						psa_pkg::REG_DATA: begin
							rdata_q <= wr_q ? 8'h00 : dm_rdata;
						end
						psa_pkg::REG_FLASH: begin
							rdata_q <= flash_rdata[7:0]; // see (RULE18)
						end
						default: begin
							rdata_q <= 8'h00; // see (RULE14) (RULE17)
						end
					endcase
					if (region_q == psa_pkg::REG_FLASH) begin
						ind_state_q <= psa_pkg::IND_EXTRA; // see (RULE19)
					end else begin
						ind_state_q <= psa_pkg::IND_IDLE;
						done_q      <= 1'b1;
					end
				end
				psa_pkg::IND_EXTRA: begin
					ind_state_q <= psa_pkg::IND_IDLE;
					done_q      <= 1'b1; // see (RULE19)
				end
				default: begin
					ind_state_q <= psa_pkg::IND_IDLE;
				end
			endcase
		end
	end

	assign ind_ready    = (ind_state_q == psa_pkg::IND_IDLE);
	assign ind_done     = done_q;
	assign ind_rdata    = rdata_q;
	assign dm_addr      = dm_addr_q;
	assign dm_wdata     = wdata_q;
	assign dm_rd        = (ind_state_q == psa_pkg::IND_MEM) && (region_q == psa_pkg::REG_DATA) && !wr_q;
	assign dm_wr        = (ind_state_q == psa_pkg::IND_MEM) && (region_q == psa_pkg::REG_DATA) && wr_q;
	assign flash_addr   = flash_addr_q;
	assign flash_rd     = (ind_state_q == psa_pkg::IND_MEM) && (region_q == psa_pkg::REG_FLASH);

	assign program_counter      = pc_q;
	assign counter_high_latch   = latch_q;
	assign stack_pointer_reg    = ptr_q;
	assign top_entry_high       = stack_q[top_idx][14:8]; // see (RULE10)
	assign top_entry_low        = stack_q[top_idx][7:0]; // see (RULE10)
	assign stack_overflow_flag  = ovf_q;
	assign stack_underflow_flag = unf_q;
	assign stack_fault_reset    = fault_q;
	assign file_select_pointer0 = sel_ptr_q[0];
	assign file_select_pointer1 = sel_ptr_q[1];
endmodule

// ===== tb/psa_unit_properties.sv
// concurrent checks on the ports of the program-flow and addressing unit
`timescale 1ns/1ps
module psa_unit_properties (
	input wire logic             ref_clk,
	input wire logic             rst_n,
	input wire logic             core_reset,
	input wire logic             op_valid,
	input wire psa_pkg::psa_op_t op,
	input wire logic             latch_wr,
	input wire logic [14:0]      program_counter,
	input wire logic [6:0]       counter_high_latch,
	input wire logic             stack_fault_reset_enable,
	input wire logic [4:0]       stack_pointer_reg,
	input wire logic             stack_overflow_flag,
	input wire logic             stack_fault_reset,
	input wire logic             flash_rd,
	input wire logic             ind_done
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic go;
	logic push;
	logic [4:0] sp;
	assign sp = stack_pointer_reg;
	assign go = op_valid && !core_reset;
	assign push = go && (op.kind inside {psa_pkg::OP_CALL, psa_pkg::OP_CALL_W,
		psa_pkg::OP_VECTOR});
	chk_low_write: assert property (go && op.kind == psa_pkg::OP_WRITE_LOW
		|=> program_counter == {$past(counter_high_latch), $past(op.low_data)})
		else $error("low byte write target wrong");
	chk_call_target: assert property (go && op.kind == psa_pkg::OP_CALL
		|=> program_counter == {$past(counter_high_latch[6:3]), $past(op.call_target)})
		else $error("call target wrong");
	chk_call_w_target: assert property (go && op.kind == psa_pkg::OP_CALL_W
		|=> program_counter == {$past(counter_high_latch), $past(op.w_value)})
		else $error("computed call target wrong");
	chk_wreg_branch: assert property (go && op.kind == psa_pkg::OP_BRANCH_W
		|=> program_counter == $past(program_counter) + 15'h1 + {7'h0, $past(op.w_value)})
		else $error("branch by w target wrong");
	chk_rel_branch: assert property (go && op.kind == psa_pkg::OP_BRANCH_REL
		|=> program_counter == $past(program_counter) + 15'h1
		+ {{6{$past(op.rel_offset[8])}}, $past(op.rel_offset)})
		else $error("relative branch target wrong");
	chk_advance_step: assert property (go && op.kind == psa_pkg::OP_ADVANCE
		|=> program_counter == $past(program_counter) + 15'h1)
		else $error("advance step wrong");
	chk_push_order: assert property (push && (sp < 5'h0f || sp == 5'h1f)
		|=> stack_pointer_reg == $past(stack_pointer_reg) + 5'h1)
		else $error("push pointer step wrong");
	chk_ovf_wrap: assert property (push && sp == 5'h0f
		|=> stack_overflow_flag && stack_pointer_reg == 5'h00)
		else $error("overflow wrap or flag missing");
	chk_fault_pulse: assert property (push && sp == 5'h0f && stack_fault_reset_enable
		|=> stack_fault_reset)
		else $error("fault reset request missing");
	chk_latch_keep: assert property (go && !latch_wr && (op.kind inside {psa_pkg::OP_CALL,
		psa_pkg::OP_CALL_W, psa_pkg::OP_VECTOR, psa_pkg::OP_RETURN}) |=> $stable(counter_high_latch))
		else $error("high latch changed by stack op");
	chk_flash_extra: assert property (flash_rd |=> !ind_done ##1 ind_done)
		else $error("flash read not one cycle longer");
	chk_core_clear: assert property (core_reset
		|=> program_counter == 15'h0 && stack_pointer_reg == 5'h1f)
		else $error("device reset did not clear counter");
endmodule

// ===== tb/psa_mem_model.sv
// data memory and program flash model facing the unit
`timescale 1ns/1ps
module psa_mem_model (
	input wire logic        ref_clk,
	input wire logic [11:0] dm_addr,
	input wire logic        dm_rd,
	input wire logic        dm_wr,
	input wire logic [7:0]  dm_wdata,
	output logic [7:0]      dm_rdata,
	input wire logic [14:0] flash_addr,
	input wire logic        flash_rd,
	output logic [13:0]     flash_rdata
);
	logic [7:0] mem [0:4095];
	logic [7:0] junk_q = 8'h55;
	initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5a;
	always @(posedge ref_clk) begin
		junk_q <= ~junk_q;
		if (dm_wr) mem[dm_addr] <= dm_wdata;
	end
	// async read; unselected lines toggle every cycle
	assign dm_rdata = dm_rd ? mem[dm_addr] : junk_q;
	assign flash_rdata = flash_rd ? {6'h2a, flash_addr[7:0] ^ 8'h3c} : {junk_q[5:0], junk_q};
endmodule

// ===== tb/psa_unit_tb_top.sv
// self-checking bench of the program-flow and addressing unit
`timescale 1ns/1ps
module psa_unit_tb_top;
	logic ref_clk = 1'b0;
	logic rst_n, core_reset, op_valid, latch_wr, stack_fault_reset_enable, ptr_reg_wr;
	logic top_high_wr, top_low_wr, overflow_clear, underflow_clear, ind_valid, ind_ready;
	logic ind_done, stack_overflow_flag, stack_underflow_flag, stack_fault_reset;
	logic dm_rd, dm_wr, flash_rd, f;
	psa_pkg::psa_op_t op;
	psa_pkg::psa_ind_req_t ind_req;
	logic [14:0] program_counter, flash_addr;
	logic [6:0] latch_wdata, counter_high_latch, top_entry_high;
	logic [4:0] ptr_reg_wdata, stack_pointer_reg;
	logic [7:0] top_wdata, top_entry_low, pointer_wdata, ind_rdata, dm_wdata, dm_rdata, r;
	logic [1:0] pointer_low_wr, pointer_high_wr;
	logic [15:0] file_select_pointer0, file_select_pointer1;
	logic [11:0] dm_addr;
	logic [13:0] flash_rdata;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n;
	psa_unit DUT (.*);
	psa_mem_model u_mem (.*);
	always #4 ref_clk = ~ref_clk;
	task nx();
		@(negedge ref_clk);
	endtask
	task chk(string nm, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task fop(psa_pkg::psa_op_kind_t k, logic [10:0] ct, logic [8:0] bo, logic [7:0] w,
		logic [7:0] ld, logic [14:0] va = 15'h0000);
		// idle edge first, so op_valid never drops and rises in one step
		nx();
		op = '{k, ct, bo, w, ld, va};
		op_valid = 1'b1;
		nx();
		op_valid = 1'b0;
	endtask
	task crst();
		core_reset = 1'b1;
		nx();
		core_reset = 1'b0;
	endtask
	task wptr(logic [4:0] v);
		ptr_reg_wdata = v;
		ptr_reg_wr = 1'b1;
		nx();
		ptr_reg_wr = 1'b0;
	endtask
	task setp(int i, logic [15:0] v);
		pointer_wdata = v[7:0];
		pointer_low_wr[i] = 1'b1;
		nx();
		pointer_low_wr = 2'h0;
		pointer_wdata = v[15:8];
		pointer_high_wr[i] = 1'b1;
		nx();
		pointer_high_wr = 2'h0;
	endtask
	task ind(logic s, logic w, logic [7:0] d);
		while (ind_ready !== 1'b1) nx();
		ind_req = '{s, w, d};
		ind_valid = 1'b1;
		nx();
		ind_valid = 1'b0;
		n = 1;
		while (ind_done !== 1'b1 && n < 9) begin
			nx();
			n++;
		end
		r = ind_rdata;
	endtask
	task t_flow();
		latch_wdata = 7'h78;
		latch_wr = 1'b1;
		nx();
		latch_wr = 1'b0;
		fop(psa_pkg::OP_WRITE_LOW, 0, 0, 0, 8'h34);
		chk("pc", 16'h7834, program_counter);
		fop(psa_pkg::OP_CALL, 11'h123, 0, 0, 0);
		chk("pc", 16'h7923, program_counter);
		chk("sp", 16'h0000, stack_pointer_reg);
		chk("tos", 16'h7835, {top_entry_high, top_entry_low});
		fop(psa_pkg::OP_CALL_W, 0, 0, 8'h56, 0);
		chk("pc", 16'h7856, program_counter);
		chk("tos", 16'h7924, {top_entry_high, top_entry_low});
		fop(psa_pkg::OP_RETURN, 0, 0, 0, 0);
		chk("pc", 16'h7924, program_counter);
		chk("latch", 16'h0078, counter_high_latch);
		fop(psa_pkg::OP_RETURN, 0, 0, 0, 0);
		chk("pc", 16'h7835, program_counter);
		chk("sp", 16'h001f, stack_pointer_reg);
		fop(psa_pkg::OP_BRANCH_W, 0, 0, 8'hf0, 0);
		chk("pc", 16'h7926, program_counter);
		fop(psa_pkg::OP_BRANCH_REL, 0, 9'h1f0, 0, 0);
		chk("pc", 16'h7917, program_counter);
		fop(psa_pkg::OP_ADVANCE, 0, 0, 0, 0);
		chk("pc", 16'h7918, program_counter);
		fop(psa_pkg::OP_VECTOR, 0, 0, 0, 0, 15'h0004);
		chk("pc", 16'h0004, program_counter);
		chk("tos", 16'h7918, {top_entry_high, top_entry_low});
		chk("sp", 16'h0000, stack_pointer_reg);
		fop(psa_pkg::OP_RETURN, 0, 0, 0, 0);
		chk("pc", 16'h7918, program_counter);
		crst();
		chk("pc", 16'h0000, program_counter);
		$display("test flow done");
	endtask
	task t_stack();
		for (int k = 0; k < 17; k++) begin
			fop(psa_pkg::OP_CALL, 11'h100 + k[10:0], 0, 0, 0);
			if (k == 15) chk("sp", 16'h000f, stack_pointer_reg);
		end
		chk("sp", 16'h0000, stack_pointer_reg);
		chk("tos", 16'h0110, {top_entry_high, top_entry_low});
		chk("ovf", 16'h0001, stack_overflow_flag);
		chk("fault", 16'h0000, stack_fault_reset);
		wptr(5'h05);
		chk("tos", 16'h0105, {top_entry_high, top_entry_low});
		top_wdata = 8'h77;
		top_low_wr = 1'b1;
		nx();
		top_low_wr = 1'b0;
		chk("tos", 16'h0177, {top_entry_high, top_entry_low});
		top_wdata = 8'h12;
		top_high_wr = 1'b1;
		nx();
		top_high_wr = 1'b0;
		chk("tos", 16'h1277, {top_entry_high, top_entry_low});
		overflow_clear = 1'b1;
		nx();
		overflow_clear = 1'b0;
		chk("ovf", 16'h0000, stack_overflow_flag);
		stack_fault_reset_enable = 1'b1;
		wptr(5'h0f);
		fop(psa_pkg::OP_CALL, 11'h200, 0, 0, 0);
		f = stack_fault_reset;
		nx();
		f = f | stack_fault_reset;
		chk("fault", 16'h0001, f);
		chk("ovf", 16'h0001, stack_overflow_flag);
		stack_fault_reset_enable = 1'b0;
		crst();
		fop(psa_pkg::OP_RETURN, 0, 0, 0, 0);
		chk("pc", 16'h010f, program_counter);
		chk("unf", 16'h0001, stack_underflow_flag);
		chk("sp", 16'h001f, stack_pointer_reg);
		underflow_clear = 1'b1;
		nx();
		underflow_clear = 1'b0;
		chk("unf", 16'h0000, stack_underflow_flag);
		stack_fault_reset_enable = 1'b1;
		fop(psa_pkg::OP_RETURN, 0, 0, 0, 0);
		f = stack_fault_reset;
		nx();
		f = f | stack_fault_reset;
		chk("fault", 16'h0001, f);
		chk("unf", 16'h0001, stack_underflow_flag);
		stack_fault_reset_enable = 1'b0;
		$display("test stack done");
	endtask
	task t_ind();
		setp(0, 16'h0123);
		chk("sel0", 16'h0123, file_select_pointer0);
		ind(0, 1, 8'ha5);
		ind(0, 0, 0);
		chk("rdata", 16'h00a5, r);
		chk("cycles", 16'h0002, n[15:0]);
		setp(1, 16'h2050);
		chk("sel1", 16'h2050, file_select_pointer1);
		ind(1, 0, 0);
		chk("rdata", 16'h00fa, r);
		setp(1, 16'h29b0);
		ind(1, 0, 0);
		chk("rdata", 16'h0000, r);
		setp(0, 16'h8123);
		ind(0, 0, 0);
		chk("rdata", 16'h001f, r);
		chk("cycles", 16'h0003, n[15:0]);
		setp(0, 16'h0081);
		ind(0, 0, 0);
		chk("rdata", 16'h0000, r);
		$display("test indirect done");
	endtask
	task close_out();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge ref_clk);
		n_mismatch++;
		close_out();
	end
	initial begin
		{core_reset, op_valid, latch_wr, latch_wdata, stack_fault_reset_enable, ptr_reg_wr} = '0;
		{ptr_reg_wdata, top_high_wr, top_low_wr, top_wdata, overflow_clear, underflow_clear} = '0;
		{pointer_low_wr, pointer_high_wr, pointer_wdata, ind_valid, op, ind_req} = '0;
		rst_n = 1'b0;
		repeat (2) nx();
		rst_n = 1'b1;
		chk("pc", 16'h0000, program_counter);
		chk("sp", 16'h001f, stack_pointer_reg);
		t_flow();
		t_stack();
		t_ind();
		close_out();
	end
endmodule
bind psa_unit psa_unit_properties u_props (.*);
